// >>> hw/sln_top.sv
// Status indicator sequencing and rotary switch node configuration.
// Assumes fault/link inputs come from same-clock logic; switches are pins.
// Behaviour
// - Memory fault sets exception bit, module red
// - Memory fault stops operation and networking
// - Power-up diagnostics reported through indicator states
// - Module indicator green, red, then off
// - Then network indicator green, red, off
// - Init: module alternates green/red, network dark
// - Init done without fault: module steady green
// - Link established: network indicator green
// - Slave acts only on own address
// - Module flashes red while receiving commands
// - Critical link failure drives indicator red
// - Offline keeps module indicator dark
// - Rate switch selects three rates, default fastest
// - Rate and address only from switches
// - Address from two decimal rotary switches
// - Addresses 0..63, left tens, right units
`timescale 1ns/1ps
module sln_top #(
	parameter int unsigned QUARTER_CYC = sln_pkg::QUARTER_CYC,
	parameter int unsigned INIT_CYC    = sln_pkg::INIT_CYC,
	parameter int unsigned FLASH_CYC   = sln_pkg::FLASH_CYC,
	parameter int unsigned RX_HOLD_CYC = sln_pkg::RX_HOLD_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic [1:0]                rate_switch,
	input  wire logic [3:0]                tens_digit_switch,
	input  wire logic [3:0]                units_digit_switch,
	input  wire logic                      eeprom_fault,
	input  wire logic                      ram_fault,
	input  wire logic                      diag_done,
	input  wire logic                      link_established,
	input  wire logic                      link_failure,
	input  wire logic                      online,
	input  wire logic                      cmd_rx,
	input  wire logic [5:0]                cmd_address,
	output sln_pkg::sln_led_t              module_led,
	output sln_pkg::sln_led_t              network_led,
	output logic                           exception_status,
	output logic                           comm_enable,
	output logic                           cmd_accept,
	output sln_pkg::sln_cfg_t              node_cfg
);
	localparam logic [sln_pkg::CNT_W-1:0] Q_LAST = sln_pkg::CNT_W'(QUARTER_CYC - 1);
	localparam logic [sln_pkg::CNT_W-1:0] I_LAST = sln_pkg::CNT_W'(INIT_CYC - 1);
	localparam logic [sln_pkg::CNT_W-1:0] F_LAST = sln_pkg::CNT_W'(FLASH_CYC - 1);
	localparam logic [sln_pkg::CNT_W-1:0] R_LAST = sln_pkg::CNT_W'(RX_HOLD_CYC - 1);
	// Capture must wait until the synchroniser shows the pins, not its reset zeros
	localparam logic [2:0]                CAP_WAIT = 3'h4;

	logic [1:0] rate_s;
	logic [3:0] tens_s, units_s;

	sln_sync #(.W(10)) u_sync (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.pin   ({rate_switch, tens_digit_switch, units_digit_switch}),
		.level ({rate_s, tens_s, units_s})
	);

	sln_pkg::sln_state_t st_q, st_d;
	logic [sln_pkg::CNT_W-1:0] cnt_q, cnt_d, fl_q, fl_d, rxh_q, rxh_d;
	logic fl_ph_q, fl_ph_d, exc_q, exc_d, cap_q, cap_d;
	logic [2:0] capw_q, capw_d;
	sln_pkg::sln_cfg_t cfg_q, cfg_d;
	sln_pkg::sln_led_t mod_q, mod_d, net_q, net_d;
	logic [6:0] addr_sum;
	logic mem_fault, cnt_q_end, cnt_i_end;

	assign mem_fault = eeprom_fault | ram_fault;
	assign cnt_q_end = (cnt_q == Q_LAST);
	assign cnt_i_end = (cnt_q == I_LAST);
	assign addr_sum  = 7'(tens_s * sln_pkg::TENS_WEIGHT) + {3'h0, units_s};

	// Switch capture, once per reset after the synchroniser has settled
	always_comb begin
		capw_d = capw_q;
		cap_d  = cap_q;
		cfg_d  = cfg_q;
		if (!cap_q) begin
			if (capw_q != CAP_WAIT) begin
				capw_d = capw_q + 3'h1;
			end else begin
				cap_d = 1'b1;
				case (rate_s)
					sln_pkg::RATE_9K6:  cfg_d.rate = sln_pkg::RATE_9K6;
					sln_pkg::RATE_19K2: cfg_d.rate = sln_pkg::RATE_19K2;
					default:            cfg_d.rate = sln_pkg::RATE_38K4;
				endcase
				// Digits above nine or sums above 63 give no usable address
				cfg_d.addr_valid = (tens_s <= sln_pkg::DIGIT_MAX) && (units_s <= sln_pkg::DIGIT_MAX) &&
					(addr_sum <= {1'b0, sln_pkg::ADDR_MAX});
				cfg_d.addr = addr_sum[5:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			capw_q <= 3'h0;
			cap_q  <= 1'b0;
			cfg_q  <= '{rate: sln_pkg::RATE_38K4, addr: '0, addr_valid: 1'b0};
		end else if (ce) begin
			capw_q <= capw_d;
			cap_q  <= cap_d;
			cfg_q  <= cfg_d;
		end
	end

	// Sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q + 1'b1;
		exc_d = exc_q | mem_fault;
		case (st_q)
			sln_pkg::SLN_MOD_GREEN: if (cnt_q_end) begin st_d = sln_pkg::SLN_MOD_RED; cnt_d = '0; end
			sln_pkg::SLN_MOD_RED:   if (cnt_q_end) begin st_d = sln_pkg::SLN_NET_GREEN; cnt_d = '0; end
			sln_pkg::SLN_NET_GREEN: if (cnt_q_end) begin st_d = sln_pkg::SLN_NET_RED; cnt_d = '0; end
			sln_pkg::SLN_NET_RED:   if (cnt_q_end) begin st_d = sln_pkg::SLN_INIT; cnt_d = '0; end
			sln_pkg::SLN_INIT: begin
				// Init lasts at least the init period; diagnostics may finish earlier
				if (cnt_i_end && diag_done) begin
					st_d = sln_pkg::SLN_RUN;
				end
				if (cnt_i_end) begin
					cnt_d = cnt_q;
				end
			end
			sln_pkg::SLN_RUN: begin
				cnt_d = '0;
				if (link_failure) st_d = sln_pkg::SLN_LINK_FAIL;
			end
			sln_pkg::SLN_LINK_FAIL: cnt_d = '0;
			sln_pkg::SLN_FAULT:     cnt_d = '0;
			default: begin
				st_d  = sln_pkg::SLN_FAULT;
				cnt_d = '0;
			end
		endcase
		if (exc_d) begin
			st_d  = sln_pkg::SLN_FAULT;
			cnt_d = '0;
		end
	end

	// Flash timebase and receive activity stretch
	always_comb begin
		fl_d    = (fl_q == F_LAST) ? '0 : fl_q + 1'b1;
		fl_ph_d = (fl_q == F_LAST) ? ~fl_ph_q : fl_ph_q;
		if (cmd_accept) begin
			rxh_d = R_LAST;
		end else if (rxh_q != '0) begin
			rxh_d = rxh_q - 1'b1;
		end else begin
			rxh_d = rxh_q;
		end
	end

	// Indicator decode, registered so outputs come from flip-flops
	always_comb begin
		mod_d = sln_pkg::SLN_LED_OFF;
		net_d = sln_pkg::SLN_LED_OFF;
		case (st_q)
			sln_pkg::SLN_MOD_GREEN: mod_d = sln_pkg::SLN_LED_GREEN;
			sln_pkg::SLN_MOD_RED:   mod_d = sln_pkg::SLN_LED_RED;
			sln_pkg::SLN_NET_GREEN: net_d = sln_pkg::SLN_LED_GREEN;
			sln_pkg::SLN_NET_RED:   net_d = sln_pkg::SLN_LED_RED;
			sln_pkg::SLN_INIT:      mod_d = fl_ph_q ? sln_pkg::SLN_LED_RED : sln_pkg::SLN_LED_GREEN;
			sln_pkg::SLN_RUN: begin
				if (!online) begin
					mod_d = sln_pkg::SLN_LED_OFF;
				end else if (rxh_q != '0) begin
					mod_d = fl_ph_q ? sln_pkg::SLN_LED_RED : sln_pkg::SLN_LED_OFF;
				end else begin
					mod_d = sln_pkg::SLN_LED_GREEN;
				end
				if (link_established) net_d = sln_pkg::SLN_LED_GREEN;
			end
			sln_pkg::SLN_LINK_FAIL: net_d = sln_pkg::SLN_LED_RED;
			sln_pkg::SLN_FAULT:     mod_d = sln_pkg::SLN_LED_RED;
			default:                mod_d = sln_pkg::SLN_LED_RED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q    <= sln_pkg::SLN_MOD_GREEN;
			cnt_q   <= '0;
			exc_q   <= 1'b0;
			fl_q    <= '0;
			fl_ph_q <= 1'b0;
			rxh_q   <= '0;
			mod_q   <= sln_pkg::SLN_LED_OFF;
			net_q   <= sln_pkg::SLN_LED_OFF;
		end else if (ce) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			exc_q   <= exc_d;
			fl_q    <= fl_d;
			fl_ph_q <= fl_ph_d;
			rxh_q   <= rxh_d;
			mod_q   <= mod_d;
			net_q   <= net_d;
		end
	end

	assign module_led       = mod_q;
	assign network_led      = net_q;
	assign exception_status = exc_q;
	assign node_cfg         = cfg_q;
	assign comm_enable      = (st_q == sln_pkg::SLN_RUN) && cap_q && cfg_q.addr_valid;
	// Requests for other nodes are ignored, not answered
	assign cmd_accept       = comm_enable && online && cmd_rx && (cmd_address == cfg_q.addr);

	a_fault_red: assert property (@(posedge clk) disable iff (rst)
		ce && mem_fault |=> ##1 (module_led == sln_pkg::SLN_LED_RED) && exception_status)
		else $error("memory fault did not force module red");
	a_fault_mute: assert property (@(posedge clk) disable iff (rst)
		exception_status |-> !comm_enable && !cmd_accept)
		else $error("communication active after memory fault");
	a_seq_start: assert property (@(posedge clk)
		$fell(rst) && ce |=> (module_led == sln_pkg::SLN_LED_GREEN) || exception_status)
		else $error("power-up sequence did not start green");
	a_net_dark_init: assert property (@(posedge clk) disable iff (rst)
		st_q == sln_pkg::SLN_INIT |-> ##1 network_led == sln_pkg::SLN_LED_OFF)
		else $error("network indicator lit during init");
	a_link_red: assert property (@(posedge clk) disable iff (rst)
		ce && st_q == sln_pkg::SLN_RUN && link_failure && !mem_fault && !exception_status
		|=> ##1 network_led == sln_pkg::SLN_LED_RED)
		else $error("link failure not shown red");
	a_offline_dark: assert property (@(posedge clk) disable iff (rst)
		st_q == sln_pkg::SLN_RUN && $stable(st_q) && !online && $past(!online) && $past(ce)
		|-> module_led == sln_pkg::SLN_LED_OFF)
		else $error("module indicator lit while offline");
	a_addr_match: assert property (@(posedge clk) disable iff (rst)
		cmd_accept |-> cmd_address == node_cfg.addr && node_cfg.addr_valid)
		else $error("accepted command for another address");
	a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
		$past(cap_q) |-> $stable(node_cfg))
		else $error("configuration changed after capture");
endmodule

// >>> hw/sln_pkg.sv
// Package for the status indicator and node configuration block.
// Assumes a single 40 MHz clock; durations are converted to cycles here.
package sln_pkg;
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned QUARTER_MS    = 250;
	localparam int unsigned INIT_MS       = 5000;
	localparam int unsigned FLASH_MS      = 250;
	localparam int unsigned RX_HOLD_MS    = 100;
	localparam int unsigned QUARTER_CYC   = CLK_HZ / 1000 * QUARTER_MS;
	localparam int unsigned INIT_CYC      = CLK_HZ / 1000 * INIT_MS;
	localparam int unsigned FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
	localparam int unsigned RX_HOLD_CYC   = CLK_HZ / 1000 * RX_HOLD_MS;
	localparam int unsigned CNT_W         = 28;
	localparam int unsigned ADDR_W        = 6;
	localparam logic [5:0]  ADDR_MAX      = 6'h3F;
	localparam logic [3:0]  DIGIT_MAX     = 4'h9;
	localparam logic [6:0]  TENS_WEIGHT   = 7'h0A;
	localparam logic [1:0]  RATE_9K6      = 2'h0;
	localparam logic [1:0]  RATE_19K2     = 2'h1;
	localparam logic [1:0]  RATE_38K4     = 2'h2;

	typedef enum logic [1:0] {
		SLN_LED_OFF   = 2'h0,
		SLN_LED_GREEN = 2'h1,
		SLN_LED_RED   = 2'h2
	} sln_led_t;

	typedef enum logic [7:0] {
		SLN_MOD_GREEN = 8'h01,
		SLN_MOD_RED   = 8'h02,
		SLN_NET_GREEN = 8'h04,
		SLN_NET_RED   = 8'h08,
		SLN_INIT      = 8'h10,
		SLN_RUN       = 8'h20,
		SLN_FAULT     = 8'h40,
		SLN_LINK_FAIL = 8'h80
	} sln_state_t;

	typedef struct packed {
		logic [1:0]        rate;
		logic [ADDR_W-1:0] addr;
		logic              addr_valid;
	} sln_cfg_t;

	typedef struct packed {
		logic mem_fault;
		logic link_fail;
		logic link_up;
		logic rx_cmd;
		logic offline;
	} sln_evt_t;
endpackage

// >>> hw/sln_sync.sv
// Three-stage synchroniser with agreement filter for a W-bit pin input.
// Assumes the pin may change at any time relative to clk.
`timescale 1ns/1ps
module sln_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

	always_comb begin
		s1_d  = pin;
		s2_d  = s1_q;
		s3_d  = s2_q;
		// Only stages two and three vote; stage one may be metastable
		lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else if (ce) begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;
endmodule

// >>> verif/sln_host_model.sv
// Host controller stand-in that puts one command on the block per send pulse.
// Assumes the bench raises send for exactly one clock cycle per command.
`timescale 1ns/1ps
module sln_host_model (
	input  wire logic       clk,
	input  wire logic       send,
	input  wire logic [5:0] target,
	output logic            cmd_rx,
	output logic      [5:0] cmd_address
);
	initial begin
		cmd_rx = 1'b0;
		cmd_address = 6'h00;
	end
	// Idle address toggles so a stale target never looks like a live one
	always @(posedge clk) begin
		cmd_rx      <= send;
		cmd_address <= send ? target : ~cmd_address;
	end
endmodule

// >>> verif/status_led_and_node_config_bench.sv
// Self-checking bench for the indicator sequencer and switch configuration.
// Assumes shortened phase counts; host commands come from sln_host_model.
`timescale 1ns/1ps
module status_led_and_node_config_bench;
	typedef struct packed {
		logic [1:0] rsw;
		logic [3:0] tens;
		logic [3:0] units;
		logic [1:0] rate;
		logic [5:0] addr;
		logic       ok;
	} sln_row_t;
	localparam int QC = 8;
	localparam int IC = 64;
	localparam int LIMIT = 6000;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, send = 1'b0;
	logic [1:0] rate_switch = 2'h0;
	logic [3:0] tens_sw = 4'h4, units_sw = 4'h2;
	logic eeprom_fault = 1'b0, ram_fault = 1'b0, diag_done = 1'b1;
	logic link_est = 1'b0, link_fail = 1'b0, online = 1'b1;
	logic [5:0] target = 6'h00, cmd_address;
	logic cmd_rx, exception_status, comm_enable, cmd_accept;
	sln_pkg::sln_led_t module_led, network_led, prev;
	sln_pkg::sln_cfg_t node_cfg;
	int n_errors = 0, total_checks = 0, cycles = 0, n, k, chg;
	sln_row_t rows[5] = '{'{2'h0, 4'h4, 4'h2, 2'h0, 6'h2A, 1'b1}, '{2'h1, 4'h6, 4'h3, 2'h1, 6'h3F, 1'b1},
		'{2'h2, 4'h0, 4'h0, 2'h2, 6'h00, 1'b1}, '{2'h3, 4'h6, 4'h4, 2'h2, 6'h00, 1'b0},
		'{2'h0, 4'h1, 4'hA, 2'h0, 6'h00, 1'b0}};
	logic [6:0] cmds[5] = '{{6'h2A, 1'b1}, {6'h2B, 1'b0}, {6'h29, 1'b0}, {6'h00, 1'b0}, {6'h2A, 1'b1}};

	always #12.5 clk = ~clk;

	sln_top #(.QUARTER_CYC(QC), .INIT_CYC(IC), .FLASH_CYC(4), .RX_HOLD_CYC(6)) dut_u (.clk(clk), .rst(rst),
		.ce(ce), .rate_switch(rate_switch), .tens_digit_switch(tens_sw), .units_digit_switch(units_sw),
		.eeprom_fault(eeprom_fault), .ram_fault(ram_fault), .diag_done(diag_done), .link_established(link_est),
		.link_failure(link_fail), .online(online), .cmd_rx(cmd_rx), .cmd_address(cmd_address),
		.module_led(module_led), .network_led(network_led), .exception_status(exception_status),
		.comm_enable(comm_enable), .cmd_accept(cmd_accept), .node_cfg(node_cfg));
	sln_host_model host_u (.clk(clk), .send(send), .target(target), .cmd_rx(cmd_rx), .cmd_address(cmd_address));

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
	endtask

	// Counts falling edges until the chosen indicator shows v
	task automatic wait_led(input logic net, input sln_pkg::sln_led_t v, input int lim, output int cnt);
		cnt = 0;
		while (((net ? network_led : module_led) !== v) && cnt < lim) begin
			@(negedge clk);
			cnt++;
		end
		check((net ? network_led : module_led) === v, 1'b1, "indicator wait");
	endtask

	task automatic send_cmd(input logic [5:0] a, input logic exp);
		@(posedge clk);
		send <= 1'b1;
		target <= a;
		@(posedge clk);
		send <= 1'b0;
		@(negedge clk);
		check(cmd_accept, exp, "command accept");
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			$display("[FAIL] %0t run too long", $time);
			report_and_stop();
		end
	end

	initial begin
		foreach (rows[i]) begin
			rate_switch <= rows[i].rsw;
			tens_sw <= rows[i].tens;
			units_sw <= rows[i].units;
			do_reset();
			repeat (20) @(posedge clk);
			check(node_cfg.rate, rows[i].rate, "rate");
			check(node_cfg.addr_valid, rows[i].ok, "address valid");
			if (rows[i].ok) check(node_cfg.addr, rows[i].addr, "address");
		end
		rate_switch <= 2'h3;
		tens_sw <= 4'h4;
		units_sw <= 4'h2;
		do_reset();
		check(comm_enable, 1'b0, "enable in reset");
		wait_led(1'b0, sln_pkg::SLN_LED_GREEN, 4, n);
		wait_led(1'b0, sln_pkg::SLN_LED_RED, 16, n);
		check(n, QC, "module green time");
		wait_led(1'b1, sln_pkg::SLN_LED_GREEN, 16, n);
		check(n, QC, "module red time");
		check(module_led, sln_pkg::SLN_LED_OFF, "module off");
		wait_led(1'b1, sln_pkg::SLN_LED_RED, 16, n);
		check(n, QC, "network green time");
		wait_led(1'b1, sln_pkg::SLN_LED_OFF, 16, n);
		check(n, QC, "network red time");
		chg = 0;
		prev = module_led;
		for (k = 0; k < IC; k++) begin
			@(negedge clk);
			if (module_led !== sln_pkg::SLN_LED_OFF && module_led !== prev) chg++;
			prev = module_led;
			check(network_led, sln_pkg::SLN_LED_OFF, "network dark in init");
		end
		check(chg >= 8, 1'b1, "module alternates");
		repeat (20) @(negedge clk);
		check(module_led, sln_pkg::SLN_LED_GREEN, "module steady");
		check(comm_enable, 1'b1, "enable in run");
		link_est <= 1'b1;
		tens_sw <= 4'h1;
		rate_switch <= 2'h0;
		repeat (20) @(negedge clk);
		check(network_led, sln_pkg::SLN_LED_GREEN, "network up");
		check(node_cfg, {2'h2, 6'h2A, 1'b1}, "config held");
		foreach (cmds[i]) send_cmd(cmds[i][6:1], cmds[i][0]);
		wait_led(1'b0, sln_pkg::SLN_LED_RED, 6, n);
		online <= 1'b0;
		repeat (20) @(negedge clk);
		check(module_led, sln_pkg::SLN_LED_OFF, "offline dark");
		send_cmd(6'h2A, 1'b0);
		ce <= 1'b0;
		online <= 1'b1;
		link_fail <= 1'b1;
		repeat (6) @(negedge clk);
		check(network_led, sln_pkg::SLN_LED_GREEN, "frozen while disabled");
		ce <= 1'b1;
		repeat (6) @(negedge clk);
		check(network_led, sln_pkg::SLN_LED_RED, "link failure");
		send_cmd(6'h2A, 1'b0);
		link_fail <= 1'b0;
		for (k = 0; k < 2; k++) begin
			do_reset();
			repeat (k ? 150 : 10) @(posedge clk);
			eeprom_fault <= (k == 0);
			ram_fault <= (k == 1);
			repeat (5) @(negedge clk);
			check(exception_status, 1'b1, "exception set");
			check(module_led, sln_pkg::SLN_LED_RED, "fault red");
			eeprom_fault <= 1'b0;
			ram_fault <= 1'b0;
			repeat (120) @(negedge clk);
			check({exception_status, comm_enable}, 2'h2, "fault sticky");
			check(module_led, sln_pkg::SLN_LED_RED, "still red");
			send_cmd(6'h2A, 1'b0);
		end
		report_and_stop();
	end
endmodule
